// ---- core/ppd_pkg.sv ----
package ppd_pkg;

    // ---------------------------------------------------------------------
    // Program space geometry
    // ---------------------------------------------------------------------
    localparam int PPD_IP_W = 12;
    localparam int PPD_OFS_W = 11;
    localparam int PPD_PAGE_W = 2;
    localparam int PPD_PHYS_W = PPD_PAGE_W + PPD_OFS_W;
    localparam int PPD_STACK_DEPTH = 6;
    localparam int PPD_STACK_PTR_W = 3;

    // ---------------------------------------------------------------------
    // Page numbers and register location
    // ---------------------------------------------------------------------
    localparam logic [1:0] PPD_STATIC_PAGE = 2'h1;
    localparam logic [7:0] PPD_SELECT_ADDR = 8'hCA;
    localparam logic [1:0] PPD_SELECT_RESET = 2'h0;
    localparam int PPD_UPPER_BIT = 11;
    localparam logic [2:0] PPD_PTR_RESET = 3'h0;

endpackage : ppd_pkg

// ---- core/ppd_decoder.sv ----
`timescale 1ns/10ps
// Functional notes
// (R1) Instruction pointer is twelve bits wide.
// (R2) Lower half uses written page select.
// (R3) Static page always reachable.
// (R4) Pointer bit 11 maps to static page.
// (R5) Select value 1 reaches static page too.
// (R6) Software crosses dynamic pages via static page.
// (R7) Six levels of return-address storage.
// (R8) Select codes 0..3 choose pages 0..3.
// (R9) Select register at CAh, write only.
// (R10) Select contents undefined after reset.
// (R11) Calls and interrupts keep page select.
// (R12) Physical address is page then offset.
module ppd_decoder
    import ppd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Fetch side
    input wire logic [PPD_IP_W-1:0] instruction_pointer,
    // Data-space access port from the core (write, read and bit operation)
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic data_bit_op,
    input wire logic [7:0] data_addr,
    input wire logic [7:0] data_wdata,
    // Return-address stack
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [PPD_IP_W-1:0] push_addr,
    output logic [PPD_IP_W-1:0] return_addr,
    output logic stack_full,
    output logic stack_empty,
    output logic stack_error,
    // Program memory side
    output logic [PPD_PHYS_W-1:0] prog_mem_addr,
    output logic select_access_error
);

    typedef struct packed {
        logic [PPD_PAGE_W-1:0] program_page_select;
        logic [PPD_PHYS_W-1:0] prog_mem_addr;
        logic [PPD_STACK_DEPTH-1:0][PPD_IP_W-1:0] stack;
        logic [PPD_STACK_PTR_W-1:0] depth;
        logic stack_error;
        logic select_access_error;
    } ppd_state_t;

    ppd_state_t state;
    ppd_state_t next_state;

    function automatic logic [PPD_PAGE_W-1:0] ppd_page(
        input logic [PPD_IP_W-1:0] ip,
        input logic [PPD_PAGE_W-1:0] sel
    );
        // ------------------------------------------------------------------
        // Page choice
        // ------------------------------------------------------------------
        // (R4) Upper half static
        if (ip[PPD_UPPER_BIT]) begin
            return PPD_STATIC_PAGE;
        end
        // (R2) Lower half selected
        // (R5) Code 1 is static
        // (R8) Code gives page
        return sel;
    endfunction : ppd_page

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.select_access_error = 1'b0;
        // (R9) Write only register
        if (data_addr == PPD_SELECT_ADDR && (data_rd || data_bit_op)) begin
            next_state.select_access_error = 1'b1;
        end else if (data_addr == PPD_SELECT_ADDR && data_wr) begin
            next_state.program_page_select = data_wdata[PPD_PAGE_W-1:0];
        end
        // (R11) Stack leaves select
        // (R7) Six-level stack
        if (stack_push && !stack_pop) begin
            if (state.depth == PPD_STACK_PTR_W'(PPD_STACK_DEPTH)) begin
                next_state.stack_error = 1'b1;
            end else begin
                next_state.stack[state.depth] = push_addr;
                next_state.depth = state.depth + 3'h1;
            end
        end else if (stack_pop && !stack_push) begin
            if (state.depth == 3'h0) begin
                next_state.stack_error = 1'b1;
            end else begin
                next_state.depth = state.depth - 3'h1;
            end
        end
        // (R1) Twelve-bit pointer
        // (R3) Static always reachable
        // (R12) Page then offset
        next_state.prog_mem_addr = {ppd_page(instruction_pointer, next_state.program_page_select),
            instruction_pointer[PPD_OFS_W-1:0]};
    end

    // ----------------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------------
    // The select value has no defined reset meaning; zero is loaded only so
    // simulation stays free of unknowns. Software must write it first.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= '0;
            // (R10) Select undefined
            state.program_page_select <= PPD_SELECT_RESET;
            state.depth <= PPD_PTR_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    assign prog_mem_addr = state.prog_mem_addr;
    assign select_access_error = state.select_access_error;
    assign stack_error = state.stack_error;
    assign stack_full = (state.depth == PPD_STACK_PTR_W'(PPD_STACK_DEPTH));
    assign stack_empty = (state.depth == 3'h0);
    assign return_addr = (state.depth == 3'h0) ? '0 : state.stack[state.depth - 3'h1];

endmodule : ppd_decoder

// ---- tb/ppd_decoder_properties.sv ----
`timescale 1ns/10ps
module ppd_chk import ppd_pkg::*; (
    input wire logic ref_clk, rst_b, data_wr, data_rd, data_bit_op, stack_push, stack_pop,
    input wire logic [7:0] data_addr, data_wdata,
    input wire logic [11:0] instruction_pointer,
    input wire logic stack_full, stack_empty, stack_error, select_access_error,
    input wire logic [12:0] prog_mem_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire hit = data_addr == PPD_SELECT_ADDR;
    wire bad = (data_rd || data_bit_op) && hit;
    wire lo = !instruction_pointer[11];
    sequence s_six; stack_empty ##0 (stack_push && !stack_pop) [*6]; endsequence
    a_upper_static: assert property (!lo |=> prog_mem_addr[12:11] == PPD_STATIC_PAGE)
        else $error("upper page");
    a_offset_pass: assert property (1 |=> prog_mem_addr[10:0] == $past(instruction_pointer[10:0]))
        else $error("offset");
    a_write_page: assert property (data_wr && hit && lo |=> prog_mem_addr[12:11] == $past(data_wdata[1:0]))
        else $error("page write");
    a_keep_select: assert property (lo ##1 (lo && !(data_wr && hit)) |=> $stable(prog_mem_addr[12:11]))
        else $error("page kept");
    a_flag_set: assert property (bad |=> select_access_error)
        else $error("flag set");
    a_flag_cause: assert property (select_access_error |-> $past(bad))
        else $error("flag cause");
    a_six_deep: assert property (s_six |=> stack_full)
        else $error("depth");
    a_over_flag: assert property (stack_push && !stack_pop && stack_full |=> stack_error)
        else $error("overflow");
endmodule : ppd_chk
bind ppd_decoder ppd_chk i_chk (.*);

// ---- tb/ppd_core_model.sv ----
`timescale 1ns/10ps
module ppd_core_model import ppd_pkg::*; (
    input wire logic ref_clk, rst_b, call,
    input wire logic [11:0] target,
    output logic [11:0] instruction_pointer, push_addr,
    output logic stack_push
);
    always_ff @(posedge ref_clk) begin
        stack_push <= rst_b && call;
        push_addr <= instruction_pointer + 12'h001;
        instruction_pointer <= !rst_b ? 12'h000 : call ? target : instruction_pointer + 12'h001;
    end
endmodule : ppd_core_model

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) n_tests++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end
module testbench import ppd_pkg::*; ();
    logic ref_clk = 0, rst_b = 0, call = 0, data_wr = 0, data_rd = 0, data_bit_op = 0;
    logic stack_pop = 0, stack_push, stack_full, stack_empty, stack_error, select_access_error;
    logic [7:0] data_addr = PPD_SELECT_ADDR, data_wdata = 8'h00;
    logic [11:0] target = 12'h000, instruction_pointer, push_addr, return_addr;
    logic [12:0] prog_mem_addr;
    int fails = 0, n_tests = 0, cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    ppd_decoder i_ppd_decoder (.*);
    ppd_core_model i_ppd_core_model (.*);
    task automatic conclude;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic go(logic [11:0] t);
        @(posedge ref_clk) call <= 1;
        target <= t;
        @(posedge ref_clk) call <= 0;
        @(posedge ref_clk) #1;
    endtask : go
    task automatic pg(logic [1:0] p);
        `CHK("addr", {p, instruction_pointer[10:0] - 11'h001}, prog_mem_addr)
    endtask : pg
    task automatic t_stack;
        @(posedge ref_clk) call <= 1;
        repeat (7) @(posedge ref_clk);
        #1;
        `CHK("full", 1'b1, stack_full)
        `CHK("err", 1'b0, stack_error)
        @(posedge ref_clk) call <= 0;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("err", 1'b1, stack_error)
        pg(2'h0);
    endtask : t_stack
    task automatic t_pages;
        for (int s = 0; s < 4; s++) begin
            go(12'h800);
            @(posedge ref_clk) data_wr <= 1;
            data_wdata <= {6'h00, s[1:0]};
            @(posedge ref_clk) data_wr <= 0;
            go(12'h100);
            pg(s[1:0]);
        end
        go(12'hA00);
        pg(PPD_STATIC_PAGE);
    endtask : t_pages
    task automatic t_refuse;
        for (int k = 1; k < 3; k++) begin
            @(posedge ref_clk) {data_bit_op, data_rd} <= k[1:0];
            @(posedge ref_clk) {data_bit_op, data_rd} <= 2'h0;
            #1;
            `CHK("flag", 1'b1, select_access_error)
        end
        go(12'h300);
        pg(2'h3);
        @(posedge ref_clk) data_wr <= 1;
        data_wdata <= 8'h02;
        @(posedge ref_clk) data_wr <= 0;
        #1;
        pg(2'h2);
        `CHK("ret", 12'h001, return_addr)
        @(posedge ref_clk) stack_pop <= 1;
        repeat (5) @(posedge ref_clk);
        @(posedge ref_clk) stack_pop <= 0;
        #1;
        `CHK("empty", 1'b1, stack_empty)
        `CHK("ret", 12'h000, return_addr)
    endtask : t_refuse
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1;
        t_stack();
        t_pages();
        t_refuse();
        conclude();
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            conclude();
        end
    end
endmodule : testbench
